// ---- uscfg_top.sv ----
// Baud generation, timeout, timeguard, card, infrared and LIN configuration block
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps

module uscfg_top #(
  parameter int ERR_W = 8
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  input  wire logic                    rx_char_done,
  input  wire logic                    tx_char_done,
  input  wire logic                    card_error,
  output logic                         sck_out,
  output logic                         sck_en,
  output logic                         os_tick,
  output logic                         bit_tick,
  output logic                         tx_sync_kind,
  output logic                         rx_timeout,
  output logic                         tx_gap_busy,
  output logic [uscfg_pkg::IRF_W-1:0]  ir_filter_width,
  output logic                         ir_filter_en,
  output uscfg_pkg::uscfg_lin_ctl_t    lin_ctl
);

  if (ERR_W < 1 || ERR_W > 8) begin : g_chk
    $error("ERR_W must lie in 1..8");
  end

  // Card protocol modes
  function automatic logic is_card(input logic [3:0] m);
    is_card = (m == uscfg_pkg::MODE_CARD_A) || (m == uscfg_pkg::MODE_CARD_B);
  endfunction : is_card

  // LIN master or slave mode
  function automatic logic is_lin(input logic [3:0] m);
    is_lin = (m == uscfg_pkg::MODE_LIN_M) || (m == uscfg_pkg::MODE_LIN_S);
  endfunction : is_lin

  // Registers
  logic [31:0]                   baud_q,  baud_d;
  logic [uscfg_pkg::RTO_W-1:0]   rto_q,   rto_d;
  logic [uscfg_pkg::GAP_W-1:0]   gap_q,   gap_d;
  logic [uscfg_pkg::RATIO_W-1:0] ratio_q, ratio_d;
  logic [uscfg_pkg::IRF_W-1:0]   irf_q,   irf_d;
  logic [uscfg_pkg::LIN_W-1:0]   lin_q,   lin_d;
  logic                          lock_q,  lock_d;
  logic [8:0]                    mode_q,  mode_d;
  logic [ERR_W-1:0]              err_q,   err_d;
  logic                          tmo_q,   tmo_d;
  uscfg_pkg::uscfg_aphase_t      ap_q,    ap_d;
  logic [31:0]                   rdata_d;

  logic [15:0] cd;
  logic [2:0]  fp;
  logic [3:0]  op_mode;
  logic        card_mode;
  logic        sync_mode;
  logic        wr_now;
  logic        rd_err;

  assign cd        = baud_q[uscfg_pkg::BAUD_CD_LSB +: uscfg_pkg::BAUD_CD_W];
  assign fp        = baud_q[uscfg_pkg::BAUD_FP_LSB +: uscfg_pkg::BAUD_FP_W];
  assign op_mode   = mode_q[uscfg_pkg::MODE_SEL_LSB +: 4];
  assign card_mode = is_card(op_mode);
  assign sync_mode = mode_q[uscfg_pkg::MODE_SYNC];
  assign wr_now    = ap_q.valid && ap_q.write;
  assign rd_err    = hsel && hready && htrans == uscfg_pkg::HTRANS_NSEQ && !hwrite
                     && haddr == uscfg_pkg::ADDR_ERR;

  // Address phase capture and read data
  always_comb
  begin
    ap_d.valid = hsel && hready && htrans[1];
    ap_d.write = hwrite;
    ap_d.addr  = haddr;
    rdata_d    = uscfg_pkg::RESET_VALUE;
    case (haddr)
      uscfg_pkg::ADDR_BAUD:  rdata_d = baud_q;
      uscfg_pkg::ADDR_RTO:   rdata_d = {15'h0000, rto_q};
      uscfg_pkg::ADDR_GAP:   rdata_d = {24'h000000, gap_q};
      uscfg_pkg::ADDR_RATIO: rdata_d = {21'h000000, ratio_q};
      uscfg_pkg::ADDR_ERR:   rdata_d = {{(32-ERR_W){1'b0}}, err_q};
      uscfg_pkg::ADDR_IRF:   rdata_d = {24'h000000, irf_q};
      uscfg_pkg::ADDR_LIN:   rdata_d = {14'h0000, lin_q};
      uscfg_pkg::ADDR_LOCK:  rdata_d = {31'h00000000, lock_q};   // Key reads as zero
      uscfg_pkg::ADDR_MODE:  rdata_d = {23'h000000, mode_q};
      uscfg_pkg::ADDR_STAT:  rdata_d = {29'h00000000, lock_q, tx_gap_busy, tmo_q};
      default:               rdata_d = uscfg_pkg::RESET_VALUE;
    endcase
    if (!(ap_d.valid && !hwrite))
      rdata_d = hrdata;
  end

  // Register writes in the data phase
  always_comb
  begin
    baud_d  = baud_q;
    rto_d   = rto_q;
    gap_d   = gap_q;
    ratio_d = ratio_q;
    irf_d   = irf_q;
    lin_d   = lin_q;
    lock_d  = lock_q;
    mode_d  = mode_q;
    if (wr_now && !lock_q)
    begin
      case (ap_q.addr)
        uscfg_pkg::ADDR_BAUD:  baud_d  = {13'h0000, hwdata[18:0]};
        uscfg_pkg::ADDR_RTO:   rto_d   = hwdata[uscfg_pkg::RTO_W-1:0];
        uscfg_pkg::ADDR_GAP:   gap_d   = hwdata[uscfg_pkg::GAP_W-1:0];
        uscfg_pkg::ADDR_RATIO: ratio_d = hwdata[uscfg_pkg::RATIO_W-1:0];
        uscfg_pkg::ADDR_IRF:   irf_d   = hwdata[uscfg_pkg::IRF_W-1:0];
        uscfg_pkg::ADDR_LIN:   lin_d   = hwdata[uscfg_pkg::LIN_W-1:0];
        default:               lin_d   = lin_q;
      endcase
    end
    if (wr_now && ap_q.addr == uscfg_pkg::ADDR_MODE)
      mode_d = hwdata[8:0];
    if (wr_now && ap_q.addr == uscfg_pkg::ADDR_LOCK
        && hwdata[uscfg_pkg::LOCK_KEY_LSB +: 24] == uscfg_pkg::LOCK_KEY)
      lock_d = hwdata[uscfg_pkg::LOCK_EN_BIT];
  end

  // Card error counter: increment beats the clear-on-read, except at saturation where the clear wins
  always_comb
  begin
    err_d = err_q;
    if (rd_err)
      err_d = '0;
    if (card_error && card_mode && err_q != {ERR_W{1'b1}})
      err_d = rd_err ? ERR_W'(1) : err_q + ERR_W'(1);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q      <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      baud_q    <= '0;
      rto_q     <= '0;
      gap_q     <= '0;
      ratio_q   <= '0;
      irf_q     <= '0;
      lin_q     <= '0;
      lock_q    <= 1'b0;
      mode_q    <= '0;
      err_q     <= '0;
    end
    else
    begin
      ap_q      <= ap_d;
      hrdata    <= rdata_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      baud_q    <= baud_d;
      rto_q     <= rto_d;
      gap_q     <= gap_d;
      ratio_q   <= ratio_d;
      irf_q     <= irf_d;
      lin_q     <= lin_d;
      lock_q    <= lock_d;
      mode_q    <= mode_d;
      err_q     <= err_d;
    end
  end

  // Divider with fractional stretch of the high phase
  logic [15:0] div_q, div_d;
  logic [2:0]  acc_q, acc_d;
  logic        ext_q, ext_d;
  logic        sck_d, os_d, frac_on;
  logic [3:0]  acc_sum;

  assign frac_on = !sync_mode && !card_mode && fp != 3'h0;
  assign acc_sum = {1'b0, acc_q} + {1'b0, fp};

  always_comb
  begin
    div_d = div_q;
    acc_d = acc_q;
    ext_d = ext_q;
    os_d  = 1'b0;
    sck_d = 1'b0;
    if (cd == 16'h0000)
    begin
      div_d = 16'h0000;
      ext_d = 1'b0;
    end
    else if (div_q == cd && ext_q)
      ext_d = 1'b0;
    else if (div_q <= 16'h0001 || div_q > cd)
    begin
      os_d  = div_q == 16'h0001;
      div_d = cd;
      if (frac_on)
      begin
        acc_d = acc_sum[2:0];
        ext_d = acc_sum[3];
      end
    end
    else
      div_d = div_q - 16'h0001;
    if (cd != 16'h0000)
      sck_d = ext_q || div_d > (cd >> 1);
  end

  // Bit tick from oversampling ticks
  logic [10:0] bcnt_q, bcnt_d;
  logic [10:0] blimit;
  logic        bit_d;

  always_comb
  begin
    if (card_mode)
      blimit = ratio_q;
    else if (sync_mode)
      blimit = 11'h001;
    else if (mode_q[uscfg_pkg::MODE_OVER])
      blimit = {6'h00, uscfg_pkg::OVS_SHORT};
    else
      blimit = {6'h00, uscfg_pkg::OVS_LONG};
    bcnt_d = bcnt_q;
    bit_d  = 1'b0;
    if (blimit == 11'h000 || cd == 16'h0000)
      bcnt_d = 11'h000;
    else if (os_tick)
    begin
      if (bcnt_q + 11'h001 >= blimit)
      begin
        bcnt_d = 11'h000;
        bit_d  = 1'b1;
      end
      else
        bcnt_d = bcnt_q + 11'h001;
    end
  end

  // Receiver idle timeout and transmit timeguard, counted in bit periods
  logic [16:0] tcnt_q, tcnt_d;
  logic        arm_q,  arm_d;
  logic [7:0]  gcnt_q, gcnt_d;

  always_comb
  begin
    tcnt_d = tcnt_q;
    arm_d  = arm_q;
    tmo_d  = tmo_q;
    if (wr_now && ap_q.addr == uscfg_pkg::ADDR_STAT && hwdata[uscfg_pkg::STAT_TIMEOUT])
      tmo_d = 1'b0;
    if (rto_q == 17'h00000)
      arm_d = 1'b0;
    else if (rx_char_done)
    begin
      arm_d  = 1'b1;
      tcnt_d = 17'h00000;
    end
    else if (arm_q && bit_tick)
    begin
      tcnt_d = tcnt_q + 17'h00001;
      if (tcnt_d >= rto_q)
      begin
        arm_d = 1'b0;
        tmo_d = 1'b1;
      end
    end
    gcnt_d = gcnt_q;
    if (tx_char_done)
      gcnt_d = gap_q;
    else if (bit_tick && gcnt_q != 8'h00)
      gcnt_d = gcnt_q - 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q       <= '0;
      acc_q       <= '0;
      ext_q       <= 1'b0;
      sck_out     <= 1'b0;
      sck_en      <= 1'b0;
      os_tick     <= 1'b0;
      bcnt_q      <= '0;
      bit_tick    <= 1'b0;
      tcnt_q      <= '0;
      arm_q       <= 1'b0;
      tmo_q       <= 1'b0;
      rx_timeout  <= 1'b0;
      gcnt_q      <= '0;
      tx_gap_busy <= 1'b0;
    end
    else
    begin
      div_q       <= div_d;
      acc_q       <= acc_d;
      ext_q       <= ext_d;
      sck_out     <= sck_d && (sync_mode || card_mode);
      sck_en      <= (sync_mode || card_mode) && cd != 16'h0000;
      os_tick     <= os_d;
      bcnt_q      <= bcnt_d;
      bit_tick    <= bit_d;
      tcnt_q      <= tcnt_d;
      arm_q       <= arm_d;
      tmo_q       <= tmo_d;
      rx_timeout  <= tmo_d;
      gcnt_q      <= gcnt_d;
      tx_gap_busy <= gcnt_d != 8'h00;
    end
  end

  // Mode-qualified infrared and LIN steering
  uscfg_pkg::uscfg_lin_ctl_t lin_d_ctl;
  logic [1:0]                node_response_action;

  always_comb
  begin
    node_response_action                   = lin_q[uscfg_pkg::LIN_NODE_RESPONSE_ACTION_LSB +: 2];
    lin_d_ctl              = '0;
    if (is_lin(op_mode))
    begin
      lin_d_ctl.tx_resp      = node_response_action == uscfg_pkg::ACT_SEND;
      lin_d_ctl.rx_resp      = node_response_action == uscfg_pkg::ACT_TAKE;
      lin_d_ctl.parity_chk   = !lin_q[uscfg_pkg::LIN_PAR_BIT];
      lin_d_ctl.parity_gen   = !lin_q[uscfg_pkg::LIN_PAR_BIT]
                               && op_mode == uscfg_pkg::MODE_LIN_M;
      lin_d_ctl.len_from_reg = !lin_q[uscfg_pkg::LIN_DLM_BIT];
      if (!lin_q[uscfg_pkg::LIN_DLM_BIT])
        lin_d_ctl.resp_len = {1'b0, lin_q[uscfg_pkg::LIN_DLC_LSB +: 8]} + 9'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ir_filter_en    <= 1'b0;
      ir_filter_width <= '0;
      lin_ctl         <= '0;
      tx_sync_kind    <= 1'b0;
    end
    else
    begin
      ir_filter_en    <= op_mode == uscfg_pkg::MODE_INFRA;
      ir_filter_width <= (op_mode == uscfg_pkg::MODE_INFRA) ? irf_q : '0;
      lin_ctl         <= lin_d_ctl;
      tx_sync_kind    <= mode_q[uscfg_pkg::MODE_TXSYNC];
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_baud_write_locked;
    wr_now && lock_q && ap_q.addr == uscfg_pkg::ADDR_BAUD;
  endsequence

  // Asynchronous x16 setting at divider one with no fraction
  logic async16_on;
  assign async16_on = !sync_mode && !card_mode && !mode_q[uscfg_pkg::MODE_OVER]
                      && cd == 16'h0001 && fp == 3'h0;

  // Fifteen quiet cycles after a bit tick, unless the setting moved away
  sequence s_async16_quiet;
    (!bit_tick || !async16_on) [*8] ##1 (!bit_tick || !async16_on) [*7];
  endsequence

  lock_blocks_a: assert property (s_baud_write_locked |=> $stable(baud_q))
    else $error("Locked baud divider changed");
  err_clear_a: assert property (rd_err && !card_error |=> err_q == '0)
    else $error("Error count not cleared by read");
  err_mode_a: assert property (!card_mode && !rd_err |=> $stable(err_q))
    else $error("Error count moved outside card mode");
  ir_mode_a: assert property (ir_filter_en |-> $past(op_mode) == uscfg_pkg::MODE_INFRA)
    else $error("Infrared filter enabled outside infrared mode");
  lin_off_a: assert property (!is_lin(op_mode) |=> !lin_ctl.tx_resp && !lin_ctl.rx_resp)
    else $error("LIN response active outside LIN mode");
  lin_len_a: assert property (is_lin(op_mode) && !lin_q[uscfg_pkg::LIN_DLM_BIT]
    |=> lin_ctl.resp_len == $past({1'b0, lin_q[15:8]}) + 9'h001)
    else $error("LIN response length not field plus one");
  no_div_a: assert property (cd == 16'h0000 [*3] |-> !os_tick && !sck_en)
    else $error("Baud ticks while divider is zero");
  async16_a: assert property (async16_on && bit_tick
    |=> s_async16_quiet ##1 (bit_tick || !async16_on))
    else $error("Bit period not sixteen ticks");
  tmo_off_a: assert property ($rose(rx_timeout) |-> $past(rto_q, 2) != 17'h00000)
    else $error("Timeout raised while disabled");
  node_response_action_a: assert property (is_lin(op_mode) && lin_q[1:0] == 2'h2
    |=> !lin_ctl.tx_resp && !lin_ctl.rx_resp)
    else $error("Ignore action still moves response");

endmodule : uscfg_top

// ---- uscfg_pkg.sv ----
// Register map, field layout, mode codes and carriers of the serial timing/config block
package uscfg_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_BAUD  = 32'h4000c220;
  localparam logic [31:0] ADDR_RTO   = 32'h4000c224;
  localparam logic [31:0] ADDR_GAP   = 32'h4000c228;
  localparam logic [31:0] ADDR_RATIO = 32'h4000c240;
  localparam logic [31:0] ADDR_ERR   = 32'h4000c244;
  localparam logic [31:0] ADDR_IRF   = 32'h4000c24c;
  localparam logic [31:0] ADDR_LIN   = 32'h4000c254;
  localparam logic [31:0] ADDR_LOCK  = 32'h4000c2e4;
  localparam logic [31:0] ADDR_MODE  = 32'h4000c2f0;
  localparam logic [31:0] ADDR_STAT  = 32'h4000c2f4;

  // Field positions and widths
  localparam int BAUD_CD_LSB  = 0;
  localparam int BAUD_CD_W    = 16;
  localparam int BAUD_FP_LSB  = 16;
  localparam int BAUD_FP_W    = 3;
  localparam int RTO_W        = 17;
  localparam int GAP_W        = 8;
  localparam int RATIO_W      = 11;
  localparam int IRF_W        = 8;
  localparam int LIN_NODE_RESPONSE_ACTION_LSB = 0;
  localparam int LIN_PAR_BIT  = 2;
  localparam int LIN_DLM_BIT  = 5;
  localparam int LIN_DLC_LSB  = 8;
  localparam int LIN_W        = 18;
  localparam int LOCK_EN_BIT  = 0;
  localparam int LOCK_KEY_LSB = 8;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_SYNC    = 4;
  localparam int MODE_OVER    = 5;
  localparam int MODE_TXSYNC  = 8;
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_GAP     = 1;
  localparam int STAT_LOCK    = 2;

  // Values
  localparam logic [23:0] LOCK_KEY     = 24'h555341;
  localparam logic [31:0] RESET_VALUE  = 32'h0000_0000;
  localparam logic [4:0]  OVS_LONG     = 5'h10;
  localparam logic [4:0]  OVS_SHORT    = 5'h08;
  localparam logic [3:0]  MODE_CARD_A  = 4'h4;
  localparam logic [3:0]  MODE_CARD_B  = 4'h6;
  localparam logic [3:0]  MODE_INFRA   = 4'h8;
  localparam logic [3:0]  MODE_LIN_M   = 4'ha;
  localparam logic [3:0]  MODE_LIN_S   = 4'hb;
  localparam logic [1:0]  ACT_SEND     = 2'h0;
  localparam logic [1:0]  ACT_TAKE     = 2'h1;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;

  // Captured address phase
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic        valid;
  } uscfg_aphase_t;

  // LIN response steering
  typedef struct packed {
    logic       tx_resp;
    logic       rx_resp;
    logic       parity_gen;
    logic       parity_chk;
    logic       len_from_reg;
    logic [8:0] resp_len;
  } uscfg_lin_ctl_t;

endpackage : uscfg_pkg

// ---- uscfg_line_model.sv ----
// Far-side serial node model: raises character and card-error events
`timescale 1ns/100ps

module uscfg_line_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      rx_char_done,
  output logic      tx_char_done,
  output logic      card_error
);
  // One-cycle event, launched just after an edge: 0 rx, 1 tx, 2 card error
  task automatic pulse(input int kind);
    @(posedge hclk);
    {rx_char_done, tx_char_done, card_error} <= 3'h4 >> kind;
    @(posedge hclk);
    {rx_char_done, tx_char_done, card_error} <= 3'h0;
  endtask : pulse

  // Line is quiet until the bench asks for an event
  initial
  begin
    rx_char_done = 1'b0;
    tx_char_done = 1'b0;
    card_error   = 1'b0;
  end
endmodule : uscfg_line_model

// ---- usart_baud_timing_lin_config_tb.sv ----
// Self-checking bench for the serial timing and configuration block
`timescale 1ns/100ps

module usart_baud_timing_lin_config_tb;
  logic                    hclk;
  logic                    hresetn;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic                    hreadyout;
  logic [31:0]             hrdata;
  logic                    hresp;
  logic                    rx_char_done;
  logic                    tx_char_done;
  logic                    card_error;
  logic                    sck_out;
  logic                    os_tick;
  logic                    sck_en;
  logic                    bit_tick;
  logic                    tx_sync_kind;
  logic                    rx_timeout;
  logic                    tx_gap_busy;
  logic [7:0]              ir_filter_width;
  logic                    ir_filter_en;
  uscfg_pkg::uscfg_lin_ctl_t lin_ctl;
  int                      err_total = 0;
  int                      comparisons = 0;
  int                      cyc = 0;
  logic [31:0]             ra [6] = '{uscfg_pkg::ADDR_BAUD, uscfg_pkg::ADDR_RTO,
    uscfg_pkg::ADDR_GAP, uscfg_pkg::ADDR_RATIO, uscfg_pkg::ADDR_IRF, uscfg_pkg::ADDR_LIN};
  logic [31:0]             rm [6] = '{32'h0007ffff, 32'h0001ffff, 32'h000000ff,
    32'h000007ff, 32'h000000ff, 32'h0003ffff};

  uscfg_top i_uscfg_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_char_done(rx_char_done),
    .tx_char_done(tx_char_done), .card_error(card_error), .sck_out(sck_out), .sck_en(sck_en),
    .os_tick(os_tick), .bit_tick(bit_tick), .tx_sync_kind(tx_sync_kind),
    .rx_timeout(rx_timeout), .tx_gap_busy(tx_gap_busy), .ir_filter_width(ir_filter_width),
    .ir_filter_en(ir_filter_en), .lin_ctl(lin_ctl));

  uscfg_line_model i_uscfg_line_model (.hclk(hclk), .hresetn(hresetn),
    .rx_char_done(rx_char_done), .tx_char_done(tx_char_done), .card_error(card_error));

  // 20 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Verdict and end of run
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      end_sim();
    end
  end

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Wait edges, then step past the edge so flop outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : wt

  // One bus transfer: address phase, then data phase, each held until hready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= uscfg_pkg::HTRANS_NSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(a, 1'b1, d, x);
    wt(1);
  endtask : wr

  task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(a, 1'b0, 32'h0, x);
    chk(nm, exp, x);
  endtask : rdc

  // Cycles between the second and third bit ticks, 0 if fewer than three come
  task automatic per(input string nm, input int exp);
    int n;
    int k;
    int d;
    n = 0;
    k = 0;
    d = 0;
    repeat (400)
    begin
      @(posedge hclk);
      n++;
      if (bit_tick === 1'b1)
      begin
        k++;
        if (k == 3) d = n;
        n = 0;
      end
    end
    chk(nm, 32'(exp), 32'(d));
  endtask : per

  // Rising edges of the clock output and oversampling ticks over 12 cycles
  task automatic clk_cnt(input string nm, input int exp);
    int   r;
    int   o;
    logic p;
    r = 0;
    o = 0;
    p = sck_out;
    repeat (12)
    begin
      @(posedge hclk);
      if (sck_out === 1'b1 && p !== 1'b1) r++;
      if (os_tick === 1'b1) o++;
      p = sck_out;
    end
    chk({nm, "_sck"}, 32'(exp), 32'(r));
    chk({nm, "_os"}, 32'(exp), 32'(o));
  endtask : clk_cnt

  // Main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wt(4);
    hresetn <= 1'b1;
    // Reset values, stored field widths, read-only and unmapped places
    for (int i = 0; i < 6; i++)
    begin
      rdc("reset", ra[i], 32'h0);
      wr(ra[i], 32'hffffffff);
      rdc("mask", ra[i], rm[i]);
    end
    wr(uscfg_pkg::ADDR_ERR, 32'hffffffff);
    rdc("err_ro", uscfg_pkg::ADDR_ERR, 32'h0);
    wr(32'h4000c230, 32'hffffffff);
    rdc("unmapped", 32'h4000c230, 32'h0);
    // Write lock with wrong and right keys
    wr(uscfg_pkg::ADDR_BAUD, 32'h5);
    wr(uscfg_pkg::ADDR_LOCK, 32'h12345601);
    rdc("badkey", uscfg_pkg::ADDR_LOCK, 32'h0);
    wr(uscfg_pkg::ADDR_LOCK, {uscfg_pkg::LOCK_KEY, 8'h01});
    rdc("lock", uscfg_pkg::ADDR_LOCK, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      wr(ra[i], 32'h0);
      rdc("locked", ra[i], (i == 0) ? 32'h5 : rm[i]);
      chk("locked_resp", 32'h0, 32'(hresp));
    end
    wr(uscfg_pkg::ADDR_LOCK, 32'h00000000);
    rdc("badclr", uscfg_pkg::ADDR_LOCK, 32'h1);
    wr(uscfg_pkg::ADDR_LOCK, {uscfg_pkg::LOCK_KEY, 8'h00});
    for (int i = 0; i < 6; i++) wr(ra[i], 32'h0);
    // Sync kind bit
    wr(uscfg_pkg::ADDR_MODE, 32'h100);
    chk("sync_kind1", 32'h1, 32'(tx_sync_kind));
    wr(uscfg_pkg::ADDR_MODE, 32'h0);
    chk("sync_kind0", 32'h0, 32'(tx_sync_kind));
    // Bit periods in async x16, async x8, sync and card modes
    wr(uscfg_pkg::ADDR_BAUD, 32'h1);
    per("async16", 16);
    wr(uscfg_pkg::ADDR_MODE, 32'h20);
    per("async8", 8);
    wr(uscfg_pkg::ADDR_BAUD, 32'h40002);
    per("fraction", 20);
    wr(uscfg_pkg::ADDR_MODE, 32'h10);
    wr(uscfg_pkg::ADDR_BAUD, 32'h3);
    per("sync", 3);
    chk("sck_en", 32'h1, 32'(sck_en));
    clk_cnt("sync", 4);
    wr(uscfg_pkg::ADDR_BAUD, 32'h0);
    per("cd_zero", 0);
    chk("sck_off", 32'h0, 32'(sck_en));
    clk_cnt("cd_zero", 0);
    wr(uscfg_pkg::ADDR_MODE, 32'h4);
    wr(uscfg_pkg::ADDR_BAUD, 32'h2);
    wr(uscfg_pkg::ADDR_RATIO, 32'h3);
    per("card", 6);
    wr(uscfg_pkg::ADDR_RATIO, 32'h0);
    per("ratio_zero", 0);
    // Card error counter
    repeat (3) i_uscfg_line_model.pulse(2);
    rdc("err3", uscfg_pkg::ADDR_ERR, 32'h3);
    rdc("err_clr", uscfg_pkg::ADDR_ERR, 32'h0);
    wr(uscfg_pkg::ADDR_MODE, 32'h0);
    i_uscfg_line_model.pulse(2);
    rdc("err_mode", uscfg_pkg::ADDR_ERR, 32'h0);
    // Receiver timeout, bit period 8 cycles
    wr(uscfg_pkg::ADDR_MODE, 32'h20);
    wr(uscfg_pkg::ADDR_BAUD, 32'h1);
    wr(uscfg_pkg::ADDR_RTO, 32'h3);
    i_uscfg_line_model.pulse(0);
    wt(10);
    chk("to_early", 32'h0, 32'(rx_timeout));
    wt(30);
    chk("to_set", 32'h1, 32'(rx_timeout));
    wr(uscfg_pkg::ADDR_RTO, 32'h0);
    wr(uscfg_pkg::ADDR_STAT, 32'h1);
    i_uscfg_line_model.pulse(0);
    wt(60);
    chk("to_off", 32'h0, 32'(rx_timeout));
    // Timeguard
    wr(uscfg_pkg::ADDR_GAP, 32'h2);
    i_uscfg_line_model.pulse(1);
    wt(1);
    chk("gap_on", 32'h1, 32'(tx_gap_busy));
    wt(30);
    chk("gap_end", 32'h0, 32'(tx_gap_busy));
    wr(uscfg_pkg::ADDR_GAP, 32'h0);
    i_uscfg_line_model.pulse(1);
    wt(1);
    chk("gap_off", 32'h0, 32'(tx_gap_busy));
    // Infrared filter, width of 5 cycles of 50 ns, enabled in infrared mode only
    wr(uscfg_pkg::ADDR_IRF, 32'h5);
    wr(uscfg_pkg::ADDR_MODE, 32'h8);
    chk("ir_w", 32'h5, 32'(ir_filter_width));
    chk("ir_en", 32'h1, 32'(ir_filter_en));
    wr(uscfg_pkg::ADDR_MODE, 32'h0);
    chk("ir_off", 32'h0, {23'h0, ir_filter_en, ir_filter_width});
    // LIN node actions, parity and response length
    wr(uscfg_pkg::ADDR_MODE, 32'ha);
    for (int a = 0; a < 3; a++)
    begin
      wr(uscfg_pkg::ADDR_LIN, 32'h700 | 32'(a));
      chk("tx_resp", 32'(a == 0), 32'(lin_ctl.tx_resp));
      chk("rx_resp", 32'(a == 1), 32'(lin_ctl.rx_resp));
    end
    chk("par_gen", 32'h1, 32'(lin_ctl.parity_gen));
    chk("len_reg", 32'h1, 32'(lin_ctl.len_from_reg));
    chk("resp_len", 32'h8, 32'(lin_ctl.resp_len));
    wr(uscfg_pkg::ADDR_MODE, 32'hb);
    chk("slave_gen", 32'h0, 32'(lin_ctl.parity_gen));
    chk("slave_chk", 32'h1, 32'(lin_ctl.parity_chk));
    wr(uscfg_pkg::ADDR_MODE, 32'h0);
    chk("lin_off", 32'h0, 32'(lin_ctl));
    end_sim();
  end
endmodule : usart_baud_timing_lin_config_tb
